// File: rtl/host_indication_end.sv
`timescale 1ns/1ns
`default_nettype none
module host_indication_end
  import indication_pkg::*;
(
  input wire logic ref_clk, // system clock
  input wire logic reset, // sync reset, active high
  indication_if.host_end pins, // link to module
  input wire logic radio_off_req, // ask to disable radio
  input wire logic card_fitted, // card sits in holder
  input wire logic power_off_req, // want supply removed
  output logic supply_enable, // drives the supply switch
  output logic ring_seen, // pulse on ring rising edge
  output logic second_seen, // pulse on second rising edge
  output logic wake_level // host wake level
);
  typedef struct packed {
    logic dis_oe;
    logic card_low;
    logic supply;
    logic ring_q;
    logic sec_q;
    logic ring_seen;
    logic sec_seen;
    logic wake;
  } host_state_t;
  host_state_t state;
  host_state_t next_state;
  always_comb begin
    next_state = state;
    next_state.dis_oe = radio_off_req;
    next_state.card_low = ~card_fitted;
    next_state.supply = ~(power_off_req & pins.power_removal_safe_out);
    next_state.ring_q = pins.ring_indicate_out;
    next_state.sec_q = pins.gnss_second_pulse_out;
    next_state.ring_seen = pins.ring_indicate_out & ~state.ring_q;
    next_state.sec_seen = pins.gnss_second_pulse_out & ~state.sec_q;
    next_state.wake = pins.host_wake_out;
  end
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      state <= '0;
      state.supply <= 1'b1;
    end else begin
      state <= next_state;
    end
  end
  // only ever pulls low; ring line left without any pull-up
  assign pins.radio_disable_n_out = 1'b0;
  assign pins.radio_disable_n_oe = state.dis_oe;
  assign pins.card_tie_low_oe = state.card_low;
  assign supply_enable = state.supply;
  assign ring_seen = state.ring_seen;
  assign second_seen = state.sec_seen;
  assign wake_level = state.wake;
endmodule : host_indication_end
`default_nettype wire

// File: rtl/indication_if.sv
`timescale 1ns/1ns
`default_nettype none
interface indication_if;
  logic tx_active;
  logic radio_led_drive_low;
  logic radio_led_oe;
  logic host_wake_out;
  logic ring_indicate_out;
  logic power_removal_safe_out;
  logic gnss_second_pulse_out;
  logic card_present_in;
  logic radio_disable_n_out;
  logic radio_disable_n_oe;
  logic radio_disable_n_in;
  logic card_tie_low_oe;
  // pads resolved with internal pull-ups on open-drain lines
  assign radio_disable_n_in = radio_disable_n_oe ? radio_disable_n_out : 1'b1;
  assign card_present_in = card_tie_low_oe ? 1'b0 : 1'b1;
  modport module_end (
    output tx_active, radio_led_drive_low, radio_led_oe, host_wake_out, ring_indicate_out,
    output power_removal_safe_out, gnss_second_pulse_out,
    input card_present_in, radio_disable_n_in
  );
  modport host_end (
    input tx_active, radio_led_drive_low, radio_led_oe, host_wake_out, ring_indicate_out,
    input power_removal_safe_out, gnss_second_pulse_out,
    output radio_disable_n_out, radio_disable_n_oe, card_tie_low_oe
  );
endinterface : indication_if
`default_nettype wire

// File: rtl/indication_pkg.sv
// Operation
// - transmit activity high exactly while transmitting
// - led pad only pulls low, never high
// - host wake high on wake-worthy event
// - ring indicator pulses high per event
// - host adds no pull-up on ring line
// - power-removal safe high; host cuts only then
// - card input pulled up; absent ties low
// - rising card input inserts, falling removes
// - one aligned pulse per satellite second
// - without fix, pulse while uncertainty low
// - high uncertainty stops the second pulse (code stops it only while gnss_fix_valid is low)
// - radio disable low suppresses all radio
// - radio disable pulled up; float means normal
// - host only pulls disable low, never high
package indication_pkg;
  localparam int CLK_PERIOD_NS = 10;
  localparam int RING_PULSE_NS = 1000;
  localparam int RING_PULSE_CYCLES = (RING_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SECOND_PULSE_NS = 1000;
  localparam int SECOND_PULSE_CYCLES = (SECOND_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PULSE_CNT_W = 16;
  localparam logic PULL_UP_LEVEL = 1'b1;
endpackage : indication_pkg

// File: rtl/module_indication_signals.sv
`timescale 1ns/1ns
`default_nettype none
module module_indication_signals
  import indication_pkg::*;
#(
  parameter int RING_WIDTH = RING_PULSE_CYCLES,
  parameter int SECOND_WIDTH = SECOND_PULSE_CYCLES
) (
  input wire logic ref_clk, // system clock
  input wire logic reset, // sync reset, active high
  indication_if.module_end pins, // link to host
  input wire logic tx_request, // radio wants to transmit
  input wire logic led_on, // light the status led
  input wire logic wake_event, // wake-worthy event pulse
  input wire logic ring_event, // notifiable event pulse
  input wire logic shutdown_done, // supply may now be removed
  input wire logic gnss_second_tick, // satellite second boundary
  input wire logic gnss_fix_valid, // position fix held
  input wire logic gnss_uncert_high, // time uncertainty high
  input wire logic wake_clear, // drop host wake
  output logic radio_enabled, // radio may transmit and receive
  output logic card_inserted, // pulse on insertion
  output logic card_removed, // pulse on removal
  output logic card_present // registered presence level
);
  typedef struct packed {
    logic tx;
    logic led_oe;
    logic wake;
    logic safe;
    logic card_q;
    logic inserted;
    logic removed;
    logic radio_en;
    logic sec_trig;
  } mod_state_t;
  mod_state_t state;
  mod_state_t next_state;
  logic ring_pulse;
  logic second_pulse;
  always_comb begin
    next_state = state;
    next_state.radio_en = pins.radio_disable_n_in;
    next_state.tx = tx_request & pins.radio_disable_n_in;
    next_state.led_oe = led_on;
    if (wake_event) begin
      next_state.wake = 1'b1;
    end else if (wake_clear) begin
      next_state.wake = 1'b0;
    end
    next_state.safe = shutdown_done;
    next_state.card_q = pins.card_present_in;
    next_state.inserted = pins.card_present_in & ~state.card_q;
    next_state.removed = ~pins.card_present_in & state.card_q;
    next_state.sec_trig = gnss_second_tick & (gnss_fix_valid | ~gnss_uncert_high);
  end
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      state <= '0;
      state.card_q <= PULL_UP_LEVEL;
    end else begin
      state <= next_state;
    end
  end
  pulse_stretch #(.WIDTH(RING_WIDTH)) u_ring (
    .ref_clk(ref_clk),
    .reset(reset),
    .trigger(ring_event & ~reset),
    .pulse(ring_pulse)
  );
  pulse_stretch #(.WIDTH(SECOND_WIDTH)) u_second (
    .ref_clk(ref_clk),
    .reset(reset),
    .trigger(state.sec_trig),
    .pulse(second_pulse)
  );
  assign pins.tx_active = state.tx;
  assign pins.radio_led_drive_low = 1'b0;
  assign pins.radio_led_oe = state.led_oe;
  assign pins.host_wake_out = state.wake;
  assign pins.ring_indicate_out = ring_pulse;
  assign pins.power_removal_safe_out = state.safe;
  assign pins.gnss_second_pulse_out = second_pulse;
  assign radio_enabled = state.radio_en;
  assign card_inserted = state.inserted;
  assign card_removed = state.removed;
  assign card_present = state.card_q;
endmodule : module_indication_signals
`default_nettype wire

// File: rtl/pulse_stretch.sv
`timescale 1ns/1ns
`default_nettype none
module pulse_stretch
  import indication_pkg::*;
#(
  parameter int WIDTH = 100
) (
  input wire logic ref_clk, // system clock
  input wire logic reset, // sync reset
  input wire logic trigger, // start a pulse
  output logic pulse // stretched high pulse
);
  typedef struct packed {
    logic [PULSE_CNT_W-1:0] count;
    logic pulse;
  } stretch_state_t;
  stretch_state_t state;
  stretch_state_t next_state;
  always_comb begin
    next_state = state;
    if (trigger) begin
      next_state.count = PULSE_CNT_W'(WIDTH - 1);
      next_state.pulse = 1'b1;
    end else if (state.count != '0) begin
      next_state.count = state.count - 1'b1;
    end else begin
      next_state.pulse = 1'b0;
    end
  end
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end
  assign pulse = state.pulse;
endmodule : pulse_stretch
`default_nettype wire

// File: verif/indication_assertions.sv
`timescale 1ns/1ns
`default_nettype none
module indication_assertions (
  input wire logic ref_clk, // clock
  input wire logic reset, // sync reset
  input wire logic tx_active, // tx level
  input wire logic radio_led_drive_low, // led pad value
  input wire logic ring_indicate_out, // ring pulse
  input wire logic gnss_second_pulse_out, // second pulse
  input wire logic radio_disable_n_out, // host pad value
  input wire logic radio_disable_n_oe, // host pulls low
  input wire logic radio_disable_n_in, // resolved pad
  input wire logic card_tie_low_oe, // holder ties low
  input wire logic card_present_in // resolved card pad
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (reset);
  chk_led_pull_only: assert property (radio_led_drive_low == 1'h0)
    else $error("led pad value high");
  chk_tx_radio_off: assert property (!radio_disable_n_in |=> !tx_active)
    else $error("tx active while radio disabled");
  chk_ring_width: assert property ($rose(ring_indicate_out)
    |-> ring_indicate_out[*3] ##1 !ring_indicate_out) else $error("ring width wrong");
  chk_second_width: assert property ($rose(gnss_second_pulse_out)
    |-> gnss_second_pulse_out[*3] ##1 !gnss_second_pulse_out) else $error("second width wrong");
  chk_disable_pullup: assert property (!radio_disable_n_oe |-> radio_disable_n_in)
    else $error("released disable pad low");
  chk_host_never_high: assert property (radio_disable_n_oe |-> !radio_disable_n_out)
    else $error("host drives disable high");
  chk_card_pullup: assert property (!card_tie_low_oe |-> card_present_in)
    else $error("released card pad low");
  chk_disable_low_cause: assert property (!radio_disable_n_in |-> radio_disable_n_oe)
    else $error("disable low without host");
  chk_ring_low_boot: assert property ($fell(reset) |-> !ring_indicate_out)
    else $error("ring line high after reset");
  cover property ($rose(ring_indicate_out));
  cover property ($rose(gnss_second_pulse_out));
  cover property ($fell(radio_disable_n_in));
endmodule : indication_assertions
`default_nettype wire

// File: verif/testbench.sv
`timescale 1ns/1ns
`default_nettype none
module testbench;
  import indication_pkg::*;
  logic ref_clk, reset, tx_request, led_on, wake_event, ring_event, shutdown_done;
  logic gnss_second_tick, gnss_fix_valid, gnss_uncert_high, wake_clear;
  logic radio_off_req, card_fitted, power_off_req;
  logic radio_enabled, card_inserted, card_removed, card_present;
  logic supply_enable, ring_seen, second_seen, wake_level;
  int miscompares = 0;
  int n_compared = 0;
  int cnt [6];
  logic [9:0] rows [6] = '{10'h213, 10'h302, 10'h08B, 10'h023, 10'h047, 10'h065};
  indication_if indication_if_inst ();
  module_indication_signals #(.RING_WIDTH(3), .SECOND_WIDTH(3)) module_indication_signals_inst (
    .ref_clk, .reset, .pins(indication_if_inst), .tx_request, .led_on, .wake_event,
    .ring_event, .shutdown_done, .gnss_second_tick, .gnss_fix_valid, .gnss_uncert_high,
    .wake_clear, .radio_enabled, .card_inserted, .card_removed, .card_present);
  host_indication_end host_indication_end_inst (.ref_clk, .reset, .pins(indication_if_inst),
    .radio_off_req, .card_fitted, .power_off_req, .supply_enable, .ring_seen, .second_seen,
    .wake_level);
  indication_assertions indication_assertions_inst (.ref_clk, .reset,
    .tx_active(indication_if_inst.tx_active),
    .radio_led_drive_low(indication_if_inst.radio_led_drive_low),
    .ring_indicate_out(indication_if_inst.ring_indicate_out),
    .gnss_second_pulse_out(indication_if_inst.gnss_second_pulse_out),
    .radio_disable_n_out(indication_if_inst.radio_disable_n_out),
    .radio_disable_n_oe(indication_if_inst.radio_disable_n_oe),
    .radio_disable_n_in(indication_if_inst.radio_disable_n_in),
    .card_tie_low_oe(indication_if_inst.card_tie_low_oe),
    .card_present_in(indication_if_inst.card_present_in));
  task summarize;
    if (miscompares == 0 && n_compared > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : summarize
  task chk(input string name, input logic [9:0] exp, input logic [9:0] got);
    n_compared++;
    if (got !== exp) begin
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
      miscompares++;
    end
  endtask : chk
  // samples just after each edge and counts high cycles
  task count(input int n);
    cnt = '{default: 0};
    repeat (n) begin
      #1;
      cnt[0] += indication_if_inst.ring_indicate_out;
      cnt[1] += indication_if_inst.gnss_second_pulse_out;
      cnt[2] += ring_seen;
      cnt[3] += card_inserted;
      cnt[4] += card_removed;
      cnt[5] += second_seen;
      @(posedge ref_clk);
    end
  endtask : count
  initial begin
    ref_clk = 1'h0;
    forever #5 ref_clk = ~ref_clk;
  end
  initial begin
    #20000;
    miscompares++;
    summarize();
  end
  initial begin
    reset = 1'h1;
    {tx_request, led_on, wake_event, ring_event, shutdown_done, gnss_second_tick} = 6'h00;
    {gnss_fix_valid, gnss_uncert_high, wake_clear, radio_off_req, card_fitted} = 5'h00;
    power_off_req = 1'h0;
    repeat (8) @(posedge ref_clk);
    reset <= 1'h0;
    foreach (rows[i]) begin
      @(posedge ref_clk) {tx_request, radio_off_req, led_on, shutdown_done, power_off_req} <= rows[i][9:5];
      repeat (4) @(posedge ref_clk);
      #1 chk("levels", {5'h00, rows[i][4:0]}, {indication_if_inst.tx_active, indication_if_inst.radio_led_oe, indication_if_inst.power_removal_safe_out, supply_enable, radio_enabled});
    end
    @(posedge ref_clk) ring_event <= 1'h1;
    @(posedge ref_clk) ring_event <= 1'h0;
    count(10);
    chk("ring", 10'hD, 10'(cnt[0] * 4 + cnt[2]));
    for (int i = 0; i < 3; i++) begin
      @(posedge ref_clk) {gnss_fix_valid, gnss_uncert_high, gnss_second_tick} <= {i == 0, i != 1, 1'h1};
      @(posedge ref_clk) gnss_second_tick <= 1'h0;
      count(10);
      chk("second", (i == 2) ? 10'h0 : 10'hD, 10'(cnt[1] * 4 + cnt[5]));
    end
    @(posedge ref_clk) wake_event <= 1'h1;
    @(posedge ref_clk) wake_event <= 1'h0;
    repeat (3) @(posedge ref_clk);
    #1 chk("wake", 10'h3, {8'h00, indication_if_inst.host_wake_out, wake_level});
    @(posedge ref_clk) wake_clear <= 1'h1;
    @(posedge ref_clk) wake_clear <= 1'h0;
    repeat (3) @(posedge ref_clk);
    #1 chk("wake_clear", 10'h0, {8'h00, indication_if_inst.host_wake_out, wake_level});
    @(posedge ref_clk) card_fitted <= 1'h1;
    count(6);
    chk("card_in", 10'h09, {5'h00, cnt[3][1:0], cnt[4][1:0], card_present});
    card_fitted <= 1'h0;
    count(6);
    chk("card_out", 10'h02, {5'h00, cnt[3][1:0], cnt[4][1:0], card_present});
    // event and clear in one cycle: the set wins
    @(posedge ref_clk) {wake_event, wake_clear} <= 2'h3;
    @(posedge ref_clk) {wake_event, wake_clear} <= 2'h0;
    repeat (3) @(posedge ref_clk);
    #1 chk("wake_both", 10'h3, {8'h00, indication_if_inst.host_wake_out, wake_level});
    // mid-run reset clears the held wake and safe levels
    @(posedge ref_clk) reset <= 1'h1;
    repeat (2) @(posedge ref_clk);
    #1 chk("reset", 10'h003, {4'h0, indication_if_inst.tx_active, indication_if_inst.radio_led_oe, indication_if_inst.power_removal_safe_out, indication_if_inst.host_wake_out, supply_enable, card_present});
    @(posedge ref_clk) reset <= 1'h0;
    @(posedge ref_clk) ring_event <= 1'h1;
    @(posedge ref_clk) ring_event <= 1'h0;
    count(10);
    chk("ring_after_reset", 10'hD, 10'(cnt[0] * 4 + cnt[2]));
    summarize();
  end
endmodule : testbench
`default_nettype wire
